// >>> logic/tcc_link.sv
// Link-clock front end: byte sequencing and request handshake to the core
`timescale 1ns/1ps
module tcc_link (
    input wire logic link_clk_in,
    input wire logic link_reset_in,
    input wire logic frame_start_in,
    input wire logic wr_valid_in,
    input wire logic [7:0] wr_byte_in,
    input wire logic rd_valid_in,
    input wire logic gc_reset_in,
    output logic [7:0] rd_byte_out,
    output logic rd_done_out,
    output logic busy_out,
    tcc_xfer_if.link xf
);
    import tcc_pkg::*;

    logic ack_s;
    logic ack_seen_ff;
    logic req_ff;
    logic [1:0] kind_ff;
    logic idx_ff;
    logic [7:0] wdata_ff;
    logic first_ff;
    logic byte_idx_ff;
    logic [15:0] word_ff;
    logic ack_fire;

    tcc_sync u_ack_sync (
        .clk_in(link_clk_in),
        .reset_in(link_reset_in),
        .d_in(xf.ack_tgl),
        .q_out(ack_s)
    );

    assign ack_fire = ack_s ^ ack_seen_ff;
    assign xf.req_tgl = req_ff;
    assign xf.kind = kind_ff;
    assign xf.byte_idx = idx_ff;
    assign xf.wdata = wdata_ff;

    // Payload is set with the toggle and held until the ack returns
    always_ff @(posedge link_clk_in) begin
        if (link_reset_in) begin
            ack_seen_ff <= 1'b0;
            req_ff <= 1'b0;
            kind_ff <= OP_PTR;
            idx_ff <= 1'b0;
            wdata_ff <= 8'h00;
            busy_out <= 1'b0;
            first_ff <= 1'b1;
            byte_idx_ff <= 1'b0;
            word_ff <= 16'h0000;
            rd_byte_out <= 8'h00;
            rd_done_out <= 1'b0;
        end else begin
            ack_seen_ff <= ack_s;
            rd_done_out <= 1'b0;
            if (!busy_out) begin
                if (frame_start_in) begin
                    first_ff <= 1'b1;
                    byte_idx_ff <= 1'b0;
                end else if (gc_reset_in || wr_valid_in ||
                             (rd_valid_in && !byte_idx_ff)) begin
                    req_ff <= ~req_ff;
                    busy_out <= 1'b1;
                    idx_ff <= byte_idx_ff;
                    wdata_ff <= wr_byte_in;
                    if (gc_reset_in) begin
                        kind_ff <= OP_GC;
                    end else if (wr_valid_in) begin
                        kind_ff <= first_ff ? OP_PTR : OP_WR;
                    end else begin
                        kind_ff <= OP_RD;
                    end
                end else if (rd_valid_in) begin
                    rd_byte_out <= word_ff[7:0];
                    rd_done_out <= 1'b1;
                end
            end else if (ack_fire) begin
                busy_out <= 1'b0;
                if (kind_ff == OP_RD) begin
                    // Whole word captured so both bytes come from one result
                    word_ff <= xf.rdata;
                    rd_byte_out <= xf.rdata[15:8];
                    rd_done_out <= 1'b1;
                    byte_idx_ff <= 1'b1;
                end else if (kind_ff == OP_PTR) begin
                    first_ff <= 1'b0;
                end else if (kind_ff == OP_WR) begin
                    byte_idx_ff <= 1'b1;
                end else begin
                    first_ff <= 1'b1;
                    byte_idx_ff <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> logic/tcc_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module tcc_sync (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_ff;
    logic sync_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule

// >>> logic/tcc_top.sv
// Temperature conversion sequencing, limit flag and register file
//
// Contract
// - Continuous conversion by default; each result overwrites the temperature register.
// - rate_select picks 0.25, 1, 4 (default) or 8 Hz conversion rate.
// - Each period: one conversion, then idle for the rest of the period.
// - Conversion starts immediately after power-up or general-call reset.
// - wide_format_select 0 uses 12-bit format for result and limits.
// - wide_format_select 1 uses 13-bit format, reaching above 128 degrees.
// - power_down_request 1 finishes current conversion then shuts down; 0 continues.
// - Single-shot in shutdown runs one conversion; bit reads 0, then 1.
// - Comparator mode: flag on at or above upper, off below lower.
// - Interrupt mode: flag on beyond a limit, cleared by temperature read.
// - Eight-bit pointer, low two bits select register, reset to zero.
// - Select codes: temperature, configuration, lower limit, upper limit.
// - Results go out as two bytes, high byte first; host may stop early.
// - Byte layout of the result in normal and extended format.
// - Configuration word layout of control and status fields.
// - Flag needs 1, 2, 4 or 6 consecutive faulting conversions.
// - flag_polarity 0 makes the flag active low, 1 active high.
`timescale 1ns/1ps
module tcc_top #(
    parameter logic [31:0] CONV_CYCLES =
        32'(tcc_pkg::CONV_TIME_MS * tcc_pkg::CLK_KHZ),
    parameter logic [31:0] PERIOD_CYC_QUARTER_HZ =
        32'(tcc_pkg::PERIOD_MS_QUARTER_HZ * tcc_pkg::CLK_KHZ),
    parameter logic [31:0] PERIOD_CYC_1_HZ =
        32'(tcc_pkg::PERIOD_MS_1_HZ * tcc_pkg::CLK_KHZ),
    parameter logic [31:0] PERIOD_CYC_4_HZ =
        32'(tcc_pkg::PERIOD_MS_4_HZ * tcc_pkg::CLK_KHZ),
    parameter logic [31:0] PERIOD_CYC_8_HZ =
        32'(tcc_pkg::PERIOD_MS_8_HZ * tcc_pkg::CLK_KHZ)
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [12:0] adc_value_in,
    output logic limit_flag_out,
    input wire logic link_clk_in,
    input wire logic link_reset_in,
    input wire logic link_frame_start_in,
    input wire logic link_wr_valid_in,
    input wire logic [7:0] link_wr_byte_in,
    input wire logic link_rd_valid_in,
    input wire logic link_gc_reset_in,
    output logic [7:0] link_rd_byte_out,
    output logic link_rd_done_out,
    output logic link_busy_out
);
    import tcc_pkg::*;

    tcc_xfer_if xf ();

    tcc_state_e state_ff;
    logic [31:0] tick_ff;
    logic req_s;
    logic req_seen_ff;
    logic ack_ff;
    logic [15:0] rdata_ff;
    logic [7:0] ptr_ff;
    logic sd_ff;
    logic tm_ff;
    logic pol_ff;
    logic em_ff;
    logic [1:0] fq_ff;
    logic [1:0] rate_ff;
    logic oneshot_ff;
    logic os_read_ff;
    logic [15:0] temp_ff;
    logic [15:0] lower_ff;
    logic [15:0] upper_ff;
    logic [2:0] hi_cnt_ff;
    logic [2:0] lo_cnt_ff;
    logic cmp_ff;
    logic int_ff;
    logic seek_low_ff;

    logic op_fire;
    logic soft_rst;
    logic [1:0] sel;
    logic wr_fire;
    logic os_start;
    logic temp_read;
    logic conv_done;
    logic [12:0] cur_val;
    logic hi_fault;
    logic lo_fault;
    logic [2:0] nxt_hi_cnt;
    logic [2:0] nxt_lo_cnt;
    logic hi_hit;
    logic lo_hit;
    logic [15:0] cfg_word;

    function automatic logic [31:0] period_of(input logic [1:0] rate);
        if (rate == RATE_QUARTER_HZ) begin
            period_of = PERIOD_CYC_QUARTER_HZ;
        end else if (rate == RATE_1_HZ) begin
            period_of = PERIOD_CYC_1_HZ;
        end else if (rate == RATE_4_HZ) begin
            period_of = PERIOD_CYC_4_HZ;
        end else begin
            period_of = PERIOD_CYC_8_HZ;
        end
    endfunction

    function automatic logic [2:0] depth_of(input logic [1:0] fq);
        case (fq)
            2'h0: depth_of = FQ_N0;
            2'h1: depth_of = FQ_N1;
            2'h2: depth_of = FQ_N2;
            default: depth_of = FQ_N3;
        endcase
    endfunction

    // Limit or result word to signed 13-bit value at the current width
    function automatic logic [12:0] word_val(input logic [15:0] w,
                                             input logic em);
        word_val = em ? w[15:3] : {w[15], w[15:4]};
    endfunction

    function automatic logic [2:0] sat_inc(input logic [2:0] c);
        sat_inc = (c >= FQ_N3) ? FQ_N3 : 3'(c + 3'h1);
    endfunction

    // Polarity applied to flag and status bit alike
    function automatic logic polar(input logic active, input logic flag_polarity);
        polar = ~(active ^ flag_polarity);
    endfunction

    tcc_link u_link (
        .link_clk_in(link_clk_in),
        .link_reset_in(link_reset_in),
        .frame_start_in(link_frame_start_in),
        .wr_valid_in(link_wr_valid_in),
        .wr_byte_in(link_wr_byte_in),
        .rd_valid_in(link_rd_valid_in),
        .gc_reset_in(link_gc_reset_in),
        .rd_byte_out(link_rd_byte_out),
        .rd_done_out(link_rd_done_out),
        .busy_out(link_busy_out),
        .xf(xf.link)
    );

    tcc_sync u_req_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(xf.req_tgl),
        .q_out(req_s)
    );

    assign xf.ack_tgl = ack_ff;
    assign xf.rdata = rdata_ff;

    assign op_fire = req_s ^ req_seen_ff;
    // General-call reset restores power-up state like the reset pin
    assign soft_rst = reset_in || (op_fire && xf.kind == OP_GC);
    assign sel = ptr_ff[1:0];
    assign wr_fire = op_fire && xf.kind == OP_WR;
    assign os_start = wr_fire && !xf.byte_idx && sel == REG_CFG &&
                      xf.wdata[CFG_OS_BIT - 8] &&
                      state_ff == ST_SHUT;
    assign temp_read = op_fire && xf.kind == OP_RD && sel == REG_TEMP;
    assign conv_done = state_ff == ST_CONV &&
                       tick_ff == CONV_CYCLES - 32'h1;

    // Normal format saturates the converter value to 12 bits
    always_comb begin
        if (em_ff) begin
            cur_val = adc_value_in;
        end else if (!adc_value_in[12] && adc_value_in > NORM_MAX) begin
            cur_val = NORM_MAX;
        end else if (adc_value_in[12] && adc_value_in < NORM_MIN) begin
            cur_val = NORM_MIN;
        end else begin
            cur_val = adc_value_in;
        end
    end

    assign hi_fault = $signed(cur_val) >=
                      $signed(word_val(upper_ff, em_ff));
    assign lo_fault = $signed(cur_val) <
                      $signed(word_val(lower_ff, em_ff));
    assign nxt_hi_cnt = hi_fault ? sat_inc(hi_cnt_ff) : 3'h0;
    assign nxt_lo_cnt = lo_fault ? sat_inc(lo_cnt_ff) : 3'h0;
    assign hi_hit = conv_done && nxt_hi_cnt >= depth_of(fq_ff);
    assign lo_hit = conv_done && nxt_lo_cnt >= depth_of(fq_ff);

    assign cfg_word = {os_read_ff, RES_VALUE, fq_ff, pol_ff, tm_ff, sd_ff,
                       rate_ff, polar(cmp_ff, pol_ff), em_ff,
                       4'h0};

    // Request handshake from the link domain
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            req_seen_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            req_seen_ff <= req_s;
            if (op_fire) begin
                ack_ff <= ~ack_ff;
                if (sel == REG_TEMP) begin
                    rdata_ff <= temp_ff;
                end else if (sel == REG_CFG) begin
                    rdata_ff <= cfg_word;
                end else if (sel == REG_LOWER) begin
                    rdata_ff <= lower_ff;
                end else begin
                    rdata_ff <= upper_ff;
                end
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            state_ff <= ST_CONV;
            tick_ff <= 32'h0;
        end else begin
            case (state_ff)
                ST_CONV: begin
                    tick_ff <= tick_ff + 32'h1;
                    if (conv_done) begin
                        if (sd_ff || oneshot_ff) begin
                            state_ff <= ST_SHUT;
                            tick_ff <= 32'h0;
                        end else begin
                            state_ff <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (sd_ff) begin
                        state_ff <= ST_SHUT;
                        tick_ff <= 32'h0;
                    end else if (tick_ff >= period_of(rate_ff) - 32'h1) begin
                        state_ff <= ST_CONV;
                        tick_ff <= 32'h0;
                    end else begin
                        tick_ff <= tick_ff + 32'h1;
                    end
                end
                default: begin
                    if (os_start || !sd_ff) begin
                        state_ff <= ST_CONV;
                        tick_ff <= 32'h0;
                    end
                end
            endcase
        end
    end

    // Single-shot tracking; trigger bit reads 0 during the shot
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            oneshot_ff <= 1'b0;
            os_read_ff <= 1'b0;
        end else if (os_start) begin
            oneshot_ff <= 1'b1;
            os_read_ff <= 1'b0;
        end else if (conv_done && oneshot_ff) begin
            oneshot_ff <= 1'b0;
            os_read_ff <= 1'b1;
        end
    end

    // Pointer and writable registers, updated byte by byte
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            ptr_ff <= PTR_RESET;
            sd_ff <= 1'b0;
            tm_ff <= 1'b0;
            pol_ff <= 1'b0;
            em_ff <= 1'b0;
            fq_ff <= FQ_RESET;
            rate_ff <= RATE_RESET;
            lower_ff <= LOWER_RESET;
            upper_ff <= UPPER_RESET;
        end else if (op_fire && xf.kind == OP_PTR) begin
            ptr_ff <= xf.wdata;
        end else if (wr_fire && sel == REG_CFG) begin
            if (!xf.byte_idx) begin
                fq_ff <= xf.wdata[CFG_FQ_LO - 7 -: 2];
                pol_ff <= xf.wdata[CFG_POL_BIT - 8];
                tm_ff <= xf.wdata[CFG_TM_BIT - 8];
                sd_ff <= xf.wdata[CFG_SD_BIT - 8];
            end else begin
                rate_ff <= xf.wdata[CFG_CR_LO + 1 -: 2];
                em_ff <= xf.wdata[CFG_EM_BIT];
            end
        end else if (wr_fire && sel == REG_LOWER) begin
            if (!xf.byte_idx) begin
                lower_ff[15:8] <= xf.wdata;
            end else begin
                lower_ff[7:0] <= xf.wdata;
            end
        end else if (wr_fire && sel == REG_UPPER) begin
            if (!xf.byte_idx) begin
                upper_ff[15:8] <= xf.wdata;
            end else begin
                upper_ff[7:0] <= xf.wdata;
            end
        end
    end

    // Result capture; the temperature register ignores writes
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            temp_ff <= TEMP_RESET;
        end else if (conv_done) begin
            if (em_ff) begin
                temp_ff <= {cur_val, EXT_TAIL};
            end else begin
                temp_ff <= {cur_val[11:0], 4'h0};
            end
        end
    end

    // Fault queue counters
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            hi_cnt_ff <= 3'h0;
            lo_cnt_ff <= 3'h0;
        end else if (conv_done) begin
            hi_cnt_ff <= nxt_hi_cnt;
            lo_cnt_ff <= nxt_lo_cnt;
        end
    end

    // Comparator state, also shown as the status bit
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            cmp_ff <= 1'b0;
        end else if (hi_hit) begin
            cmp_ff <= 1'b1;
        end else if (lo_hit) begin
            cmp_ff <= 1'b0;
        end
    end

    // Interrupt state alternates between the upper and lower side
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            int_ff <= 1'b0;
            seek_low_ff <= 1'b0;
        end else if (!seek_low_ff && hi_hit) begin
            int_ff <= 1'b1;
            seek_low_ff <= 1'b1;
        end else if (seek_low_ff && lo_hit) begin
            int_ff <= 1'b1;
            seek_low_ff <= 1'b0;
        end else if (temp_read || state_ff == ST_SHUT) begin
            int_ff <= 1'b0;
        end
    end

    // Flag output registered; idle level high at the default polarity
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            limit_flag_out <= 1'b1;
        end else begin
            limit_flag_out <= polar(tm_ff ? int_ff : cmp_ff,
                                    pol_ff);
        end
    end
endmodule

// >>> shared/tcc_pkg.sv
// Constants and types shared by the temperature conversion control block
package tcc_pkg;
    // Clock rate and documented times
    localparam int unsigned CLK_KHZ = 250000;
    localparam int unsigned CONV_TIME_MS = 26;
    localparam int unsigned PERIOD_MS_QUARTER_HZ = 4000;
    localparam int unsigned PERIOD_MS_1_HZ = 1000;
    localparam int unsigned PERIOD_MS_4_HZ = 250;
    localparam int unsigned PERIOD_MS_8_HZ = 125;

    // Register selection codes (low pointer bits)
    localparam logic [1:0] REG_TEMP = 2'h0;
    localparam logic [1:0] REG_CFG = 2'h1;
    localparam logic [1:0] REG_LOWER = 2'h2;
    localparam logic [1:0] REG_UPPER = 2'h3;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // Configuration word bit positions
    localparam int CFG_OS_BIT = 15;
    localparam int CFG_RES_LO = 13;
    localparam int CFG_FQ_LO = 11;
    localparam int CFG_POL_BIT = 10;
    localparam int CFG_TM_BIT = 9;
    localparam int CFG_SD_BIT = 8;
    localparam int CFG_CR_LO = 6;
    localparam int CFG_AL_BIT = 5;
    localparam int CFG_EM_BIT = 4;

    // Reset values and fixed fields
    localparam logic [1:0] RES_VALUE = 2'h3;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [1:0] FQ_RESET = 2'h0;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] LOWER_RESET = 16'h4b00;
    localparam logic [15:0] UPPER_RESET = 16'h5000;
    localparam logic [2:0] EXT_TAIL = 3'h1;

    // Rate codes and fault queue depths
    localparam logic [1:0] RATE_QUARTER_HZ = 2'h0;
    localparam logic [1:0] RATE_1_HZ = 2'h1;
    localparam logic [1:0] RATE_4_HZ = 2'h2;
    localparam logic [2:0] FQ_N0 = 3'h1;
    localparam logic [2:0] FQ_N1 = 3'h2;
    localparam logic [2:0] FQ_N2 = 3'h4;
    localparam logic [2:0] FQ_N3 = 3'h6;

    // Normal-format clamp limits on the 13-bit converter value
    localparam logic [12:0] NORM_MAX = 13'h07ff;
    localparam logic [12:0] NORM_MIN = 13'h1800;

    // Link operation kinds
    localparam logic [1:0] OP_PTR = 2'h0;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_GC = 2'h3;

    typedef enum logic [1:0] {ST_CONV, ST_WAIT, ST_SHUT} tcc_state_e;
endpackage

// >>> shared/tcc_xfer_if.sv
// Handshake carrier between the link domain and the core domain
`timescale 1ns/1ps
interface tcc_xfer_if;
    logic req_tgl;
    logic [1:0] kind;
    logic byte_idx;
    logic [7:0] wdata;
    logic ack_tgl;
    logic [15:0] rdata;

    modport link (
        output req_tgl, kind, byte_idx, wdata,
        input ack_tgl, rdata
    );
    modport core (
        input req_tgl, kind, byte_idx, wdata,
        output ack_tgl, rdata
    );
endinterface

// >>> tb/tb_tcc_top.sv
// Register-level tests of the conversion control block
`timescale 1ns/1ps
module tb_tcc_top;
    import tcc_pkg::*;
    localparam int T = 1300;
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic link_reset_in = 1'b1;
    logic [12:0] adc_value_in = 13'h0190;
    logic limit_flag_out, link_frame_start_in, link_wr_valid_in;
    logic link_rd_valid_in, link_gc_reset_in, link_rd_done_out;
    logic link_busy_out;
    logic [7:0] link_wr_byte_in, link_rd_byte_out, b;
    logic [15:0] w;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #2 clk_in = ~clk_in;
    // Odd offset keeps the link edges off the core edges
    initial begin
        #1.3;
        forever #15 link_clk_in = ~link_clk_in;
    end
    tcc_top #(.CONV_CYCLES(32'd800), .PERIOD_CYC_QUARTER_HZ(32'd3200),
        .PERIOD_CYC_1_HZ(32'd2000), .PERIOD_CYC_4_HZ(32'd1200),
        .PERIOD_CYC_8_HZ(32'd1000)) i_tcc_top (.clk_in, .reset_in,
        .adc_value_in, .limit_flag_out, .link_clk_in, .link_reset_in,
        .link_frame_start_in, .link_wr_valid_in, .link_wr_byte_in,
        .link_rd_valid_in, .link_gc_reset_in, .link_rd_byte_out,
        .link_rd_done_out, .link_busy_out);
    tcc_host_model i_host (.lclk_in(link_clk_in), .busy_in(link_busy_out),
        .done_in(link_rd_done_out), .rbyte_in(link_rd_byte_out),
        .fs_out(link_frame_start_in), .wv_out(link_wr_valid_in),
        .wb_out(link_wr_byte_in), .rv_out(link_rd_valid_in),
        .gc_out(link_gc_reset_in));
    task automatic chk(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [15:0] cw(logic os, logic [1:0] fq,
        logic [2:0] pts, logic [1:0] cr, logic em);
        return {os, RES_VALUE, fq, pts, cr, 1'b1, em, 4'h0};
    endfunction
    task automatic wc(int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic adc(logic [12:0] v);
        @(negedge clk_in);
        adc_value_in = v;
        wc(T);
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        @(negedge link_clk_in);
        link_reset_in = 1'b0;
        wc(1000);
        i_host.op(0, 8'h00, b);
        i_host.op(2, 8'h00, w[15:8]);
        i_host.op(2, 8'h00, w[7:0]);
        chk("temp_ptr_reset", w, 16'h1900);
        i_host.rd(REG_CFG, w);
        chk("cfg_reset", w, cw(0, FQ_RESET, 3'h0, RATE_RESET, 0));
        i_host.rd(REG_LOWER, w);
        chk("lower_reset", w, LOWER_RESET);
        i_host.rd(REG_UPPER, w);
        chk("upper_reset", w, UPPER_RESET);
        adc(13'h0a00);
        i_host.rd(REG_TEMP, w);
        chk("temp_sat", w, {NORM_MAX[11:0], 4'h0});
        chk("flag_low", 16'(limit_flag_out), 16'h0);
        i_host.wr(REG_CFG, cw(0, 2'h0, 3'h4, RATE_RESET, 1));
        wc(T);
        i_host.rd(REG_TEMP, w);
        chk("temp_ext", w, {13'h0a00, EXT_TAIL});
        chk("flag_pol", 16'(limit_flag_out), 16'h1);
        adc(13'h0961);
        chk("flag_hyst", 16'(limit_flag_out), 16'h1);
        adc(13'h095f);
        chk("flag_below", 16'(limit_flag_out), 16'h0);
        i_host.op(3, 8'h00, b);
        i_host.rd(REG_CFG, w);
        chk("cfg_gc", w, cw(0, FQ_RESET, 3'h0, RATE_RESET, 0));
        i_host.wr(REG_CFG, cw(0, 2'h0, 3'h2, RATE_RESET, 0));
        wc(T);
        chk("int_set", 16'(limit_flag_out), 16'h0);
        i_host.rd(REG_TEMP, w);
        chk("int_clear", 16'(limit_flag_out), 16'h1);
        adc(13'h0a00);
        chk("int_hold", 16'(limit_flag_out), 16'h1);
        adc(13'h0100);
        chk("int_low", 16'(limit_flag_out), 16'h0);
        i_host.op(3, 8'h00, b);
        i_host.wr(REG_CFG, cw(0, 2'h3, 3'h0, 2'h3, 0));
        @(negedge clk_in);
        adc_value_in = 13'h0a00;
        wc(4000);
        chk("fq_wait", 16'(limit_flag_out), 16'h1);
        wc(3000);
        chk("fq_hit", 16'(limit_flag_out), 16'h0);
        i_host.wr(REG_CFG, cw(0, 2'h0, 3'h1, RATE_RESET, 0));
        wc(T);
        adc(13'h0190);
        i_host.rd(REG_TEMP, w);
        chk("temp_shut", w, {NORM_MAX[11:0], 4'h0});
        i_host.wr(REG_CFG, cw(1, 2'h0, 3'h1, RATE_RESET, 0));
        i_host.op(0, 8'h00, b);
        i_host.op(2, 8'h00, b);
        chk("os_busy", 16'(b[7]), 16'h0);
        wc(T);
        adc(13'h0320);
        i_host.rd(REG_CFG, w);
        chk("os_done", 16'(w[15]), 16'h1);
        i_host.rd(REG_TEMP, w);
        chk("temp_one_shot", w, 16'h1900);
        stop_test();
    end
endmodule

// >>> tb/tcc_host_model.sv
// Host model driving the link byte port
`timescale 1ns/1ps
module tcc_host_model (
    input wire logic lclk_in,
    input wire logic busy_in,
    input wire logic done_in,
    input wire logic [7:0] rbyte_in,
    output logic fs_out,
    output logic wv_out,
    output logic [7:0] wb_out,
    output logic rv_out,
    output logic gc_out
);
    initial begin
        {fs_out, wv_out, rv_out, gc_out} = 4'h0;
        wb_out = 8'h00;
    end
    // One pulse, then wait out busy; byte line shows garbage when idle
    task automatic op(input int k, input logic [7:0] b,
                      output logic [7:0] r);
        r = 8'h00;
        @(negedge lclk_in);
        wb_out <= b;
        case (k)
            0: fs_out <= 1'b1;
            1: wv_out <= 1'b1;
            2: rv_out <= 1'b1;
            default: gc_out <= 1'b1;
        endcase
        @(negedge lclk_in);
        {fs_out, wv_out, rv_out, gc_out} <= 4'h0;
        wb_out <= ~b;
        for (int i = 0; i < 40; i++) begin
            if (done_in) r = rbyte_in;
            if (i > 0 && !busy_in) break;
            @(negedge lclk_in);
        end
    endtask
    task automatic wr(input logic [1:0] p, input logic [15:0] w);
        logic [7:0] r;
        op(0, 8'h00, r);
        op(1, {6'h00, p}, r);
        op(1, w[15:8], r);
        op(1, w[7:0], r);
    endtask
    task automatic rd(input logic [1:0] p, output logic [15:0] w);
        logic [7:0] r;
        op(0, 8'h00, r);
        op(1, {6'h00, p}, r);
        op(0, 8'h00, r);
        op(2, 8'h00, w[15:8]);
        op(2, 8'h00, w[7:0]);
    endtask
endmodule

// >>> tb/tcc_top_sva.sv
// Port checker for the conversion control block
`timescale 1ns/1ps
module tcc_top_sva (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic limit_flag_out,
    input wire logic link_clk_in,
    input wire logic link_reset_in,
    input wire logic link_frame_start_in,
    input wire logic link_wr_valid_in,
    input wire logic link_rd_valid_in,
    input wire logic link_gc_reset_in,
    input wire logic [7:0] link_rd_byte_out,
    input wire logic link_rd_done_out,
    input wire logic link_busy_out
);
    a_flag_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(reset_in) |-> limit_flag_out [*8]) else $error("flag active");
    a_done_pulse: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in) link_rd_done_out |=> !link_rd_done_out)
        else $error("rd_done too long");
    a_done_idle: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in) link_rd_done_out |-> !link_busy_out)
        else $error("rd_done while busy");
    a_byte_hold: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in)
        !link_rd_done_out |-> $stable(link_rd_byte_out))
        else $error("rd_byte moved");
    a_busy_ends: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in)
        $rose(link_busy_out) |-> ##[1:20] !link_busy_out)
        else $error("busy stuck");
    a_busy_cause: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in)
        $rose(link_busy_out) |-> !$past(link_frame_start_in))
        else $error("frame start made busy");
    a_wr_taken: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in) link_wr_valid_in && !link_busy_out &&
        !link_frame_start_in && !link_gc_reset_in |-> ##[1:2] link_busy_out)
        else $error("write not taken");
    a_rd_answer: assert property (@(posedge link_clk_in)
        disable iff (link_reset_in) link_rd_valid_in && !link_busy_out &&
        !link_frame_start_in && !link_gc_reset_in && !link_wr_valid_in
        |-> ##[1:12] link_rd_done_out) else $error("read not answered");
endmodule
bind tcc_top tcc_top_sva i_tcc_top_sva (.clk_in, .reset_in,
    .limit_flag_out, .link_clk_in, .link_reset_in, .link_frame_start_in,
    .link_wr_valid_in, .link_rd_valid_in, .link_gc_reset_in,
    .link_rd_byte_out, .link_rd_done_out, .link_busy_out);
